// ---- shared/adrc_pkg.sv ----
// Package for the converter register control block: offsets, field layout, resets, types.
// Assumes a single 125 MHz system clock and an AXI4-Lite master holding 32-bit data.
// Contract
// - Each 12-bit result is held in two read-only bytes, high and low.
// - Alignment 0: bits 11..4 in high byte, bits 3..0 in low upper nibble.
// - Alignment 1: bits 11..8 in high lower nibble, bits 7..0 in low byte.
// - Result bit positions without a conversion bit read as zero.
// - Result bytes stay unchanged while the converter is disabled.
// - A conversion starts when software writes start high then low again.
// - Busy rises when a start sequence begins a conversion, falls on completion.
// - Enable must be set before converting; clear enable powers the converter off.
// - Channel codes 0..11 route analog inputs 0..11; codes 12..15 select none.
// - At most one source connects to the converter, chosen by both select fields.
// - A pin selected as converter input loses its digital shared function.
// - A pin selected as converter input has its pull-high disconnected.
// - One bandgap enable bit switches the internal reference on or off.
// - Input select decodes external, supply fractions, amplifier fractions or ground.
// - Selecting an internal signal disconnects the external channel input.
// - Clock field divides by 1,2,4,8,16,32,64,128 for codes 0..7.
// - Reference select: 00 supply, 01 external pin, 1x amplifier output.
package adrc_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_RESULT_LOW = 8'h00;
  localparam logic [7:0] OFF_RESULT_HIGH = 8'h04;
  localparam logic [7:0] OFF_MAIN_CTRL = 8'h08;
  localparam logic [7:0] OFF_INPUT_CLOCK = 8'h0C;
  localparam logic [7:0] OFF_AMP_REF = 8'h10;
  localparam logic [7:0] OFF_BANDGAP = 8'h14;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h18;
  localparam logic [7:0] OFF_IRQ_ENABLE = 8'h1C;
  localparam logic [7:0] OFF_IRQ_CLEAR = 8'h20;

  // Main control fields
  localparam int MC_START = 7;
  localparam int MC_BUSY = 6;
  localparam int MC_ENABLE = 5;
  localparam int MC_ALIGN = 4;
  localparam int MC_CHAN_LSB = 0;
  // Input/clock select fields
  localparam int IC_INSEL_LSB = 4;
  localparam int IC_CLKDIV_LSB = 0;
  // Writable bit masks
  localparam logic [7:0] MASK_MAIN = 8'hBF;
  localparam logic [7:0] MASK_INPUT_CLOCK = 8'hF7;
  localparam logic [7:0] MASK_AMP_REF = 8'h9F;
  localparam logic [7:0] MASK_BANDGAP = 8'h01;
  localparam logic [7:0] RESET_REG = 8'h00;

  localparam logic [3:0] NUM_CHANNELS = 4'hC;
  localparam logic [1:0] IRQ_BITS_RESET = 2'h0;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_IGNORED = 1;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    SRC_NONE, SRC_EXT, SRC_AVDD, SRC_AVDD_2, SRC_AVDD_4, SRC_AMP, SRC_AMP_2, SRC_AMP_4, SRC_GND
  } adrc_src_t;

  typedef enum logic [1:0] {REF_AVDD, REF_PIN, REF_AMP} adrc_ref_t;

  typedef enum {ST_IDLE, ST_CONVERT} adrc_state_t;

  // Converter core handshake
  typedef struct packed {
    logic powerOn;
    logic startPulse;
    logic convClkEn;
    adrc_src_t source;
    adrc_ref_t reference;
  } adrc_core_ctrl_t;

  typedef struct packed {
    logic done;
    logic [11:0] data;
  } adrc_core_stat_t;

endpackage : adrc_pkg

// ---- testbench/adrc_core_model.sv ----
// Behavioural analog core: finishes a conversion a set number of cycles after start.
// Assumes the bench supplies the sample value and the latency.
module adrc_core_model (
  input wire logic clk, // System clock
  input wire logic reset, // Async reset
  input wire adrc_pkg::adrc_core_ctrl_t coreCtrl, // Controls from block
  input wire logic [11:0] sample, // Value to convert
  input wire logic [7:0] latency, // Cycles to completion
  output adrc_pkg::adrc_core_stat_t coreStat // Done and data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt;
  logic [11:0] last;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt <= 8'h00;
      last <= 12'h000;
      coreStat <= '0;
    end else begin
      coreStat.done <= 1'b0;
      // Data is not held after done
      coreStat.data <= ~last;
      if (!coreCtrl.powerOn) begin
        cnt <= 8'h00;
      end else if (coreCtrl.startPulse) begin
        cnt <= latency;
      end else if (cnt == 8'h01) begin
        cnt <= 8'h00;
        coreStat.done <= 1'b1;
        coreStat.data <= sample;
        last <= sample;
      end else if (cnt != 8'h00) begin
        cnt <= cnt - 8'h01;
      end
    end
  end
endmodule : adrc_core_model

// ---- testbench/adrc_register_control_properties.sv ----
// Port checker for the converter register control block.
// Assumes it is bound to adrc_register_control and sees one clock domain.
module adrc_checker (
  input wire logic clk, // System clock
  input wire logic reset, // Async reset
  input wire adrc_pkg::adrc_core_ctrl_t coreCtrl, // Core controls
  input wire logic [11:0] channelConnect, // Channel switches
  input wire logic [11:0] pinAnalogSelect, // Analog pin select
  input wire logic [11:0] pinDigitalEnable, // Digital function kept
  input wire logic [11:0] pinPullRequest, // Pull requested
  input wire logic [11:0] pinPullEnable // Pull applied
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  property p_dig; pinDigitalEnable == ~pinAnalogSelect; endproperty
  a_dig: assert property (p_dig) else $error("digital function left on analog pin");
  property p_pull; pinPullEnable == (pinPullRequest & ~pinAnalogSelect); endproperty
  a_pull: assert property (p_pull) else $error("pull-high left on analog pin");
  property p_one; $onehot0(channelConnect); endproperty
  a_one: assert property (p_one) else $error("several channels connected");
  property p_ext; coreCtrl.source != adrc_pkg::SRC_EXT |-> channelConnect == 12'h000; endproperty
  a_ext: assert property (p_ext) else $error("channel connected with internal source");
  property p_chan; channelConnect != 12'h000 |-> coreCtrl.source == adrc_pkg::SRC_EXT; endproperty
  a_chan: assert property (p_chan) else $error("channel connected without external source");
  property p_off; !coreCtrl.powerOn |-> channelConnect == 12'h000 && coreCtrl.source == adrc_pkg::SRC_NONE;
  endproperty
  a_off: assert property (p_off) else $error("converter routed while disabled");
  property p_on; coreCtrl.startPulse |-> coreCtrl.powerOn; endproperty
  a_on: assert property (p_on) else $error("start while disabled");
  property p_pulse; coreCtrl.startPulse |=> !coreCtrl.startPulse [*3]; endproperty
  a_pulse: assert property (p_pulse) else $error("start pulse repeated");
endmodule : adrc_checker

bind adrc_register_control adrc_checker u_chk (.clk(clk), .reset(reset), .coreCtrl(coreCtrl),
  .channelConnect(channelConnect), .pinAnalogSelect(pinAnalogSelect), .pinDigitalEnable(pinDigitalEnable),
  .pinPullRequest(pinPullRequest), .pinPullEnable(pinPullEnable));

// ---- testbench/adrc_register_control_tb.sv ----
// Self-checking bench for the converter register control block.
// Assumes the core model and the bound checker; AXI4-Lite master tasks.
module adrc_register_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, reset, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, al;
  logic ampEnable, ampInputSel, bandgapEnable;
  logic [1:0] s_axi_bresp, s_axi_rresp, ampGain, rsp;
  logic [3:0] s_axi_wstrb;
  logic [7:0] s_axi_awaddr, s_axi_araddr, latency;
  logic [31:0] s_axi_wdata, s_axi_rdata, rs, rd, v, w, eh, el;
  logic [11:0] channelConnect, pinAnalogSelect, pinDigitalEnable, pinPullRequest, pinPullEnable, sample;
  adrc_pkg::adrc_core_ctrl_t coreCtrl;
  adrc_pkg::adrc_core_stat_t coreStat;
  int n_fail, checks, ch, ex;
  int gap = 0;
  int expQ[$];
  logic [2:0] divCode = 3'h0;
  adrc_register_control DUT (
    .clk(clk), .reset(reset),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .coreCtrl(coreCtrl), .coreStat(coreStat), .channelConnect(channelConnect),
    .pinAnalogSelect(pinAnalogSelect), .pinDigitalEnable(pinDigitalEnable),
    .pinPullRequest(pinPullRequest), .pinPullEnable(pinPullEnable),
    .ampEnable(ampEnable), .ampInputSel(ampInputSel), .ampGain(ampGain),
    .bandgapEnable(bandgapEnable), .irq(irq)
  );
  adrc_core_model core (
    .clk(clk), .reset(reset), .coreCtrl(coreCtrl), .sample(sample), .latency(latency), .coreStat(coreStat)
  );
  // Spacing of conversion clock ticks, counted on falling edges where outputs are settled
  always @(negedge clk) begin
    if (coreCtrl.startPulse) begin
      gap = 0;
    end else if (coreCtrl.convClkEn) begin
      if (gap > 0) chk("divider period", gap, 32'h1 << divCode);
      gap = 1;
    end else if (gap > 0) begin
      gap++;
    end
  end
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction : rnd
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic aT, wT, bT;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    bT = 1'b0;
    while (!bT) begin
      @(negedge clk);
      {aT, wT, bT} = {s_axi_awready, s_axi_wready, s_axi_bvalid};
      @(posedge clk);
      if (aT) s_axi_awvalid <= 1'b0;
      if (wT) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd8(input logic [7:0] a);
    logic aT, rT;
    @(posedge clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    rT = 1'b0;
    while (!rT) begin
      @(negedge clk);
      {aT, rT, rd, rsp} = {s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp};
      @(posedge clk);
      if (aT) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask : rd8
  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    rd8(a);
    chk(what, rd, exp);
  endtask : rchk
  task automatic close_out();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    close_out();
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    {rs, n_fail, checks, reset} = {32'h0000F247, 32'h0, 32'h0, 1'b1};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, latency} = {48'h0, 4'hF, 8'h10};
    {pinAnalogSelect, pinPullRequest, sample} = 36'h0;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    for (int a = 0; a < 40; a += 4) begin
      rd8(a[7:0]);
      chk("reset value", rd, 32'h0);
      chk("response", {30'h0, rsp}, {30'h0, (a < 36) ? adrc_pkg::RESP_OKAY : adrc_pkg::RESP_SLVERR});
    end
    for (int i = 0; i < 16; i++) begin
      {v, w} = {rnd(), rnd()};
      {pinAnalogSelect, pinPullRequest} <= w[23:0];
      ch = v[31:28];
      wr(adrc_pkg::OFF_INPUT_CLOCK, {i[3:0], v[3:0]});
      wr(adrc_pkg::OFF_AMP_REF, v[15:8]);
      wr(adrc_pkg::OFF_BANDGAP, v[23:16]);
      wr(adrc_pkg::OFF_MAIN_CTRL, {4'h2, v[31:28]});
      @(negedge clk);
      chk("pull", {20'h0, pinPullEnable}, {20'h0, w[11:0] & ~w[23:12]});
      chk("bandgap", {31'h0, bandgapEnable}, {31'h0, v[16]});
      chk("reference", coreCtrl.reference,
          v[11] ? adrc_pkg::REF_AMP : v[10] ? adrc_pkg::REF_PIN : adrc_pkg::REF_AVDD);
      chk("amp controls", {28'h0, ampEnable, ampInputSel, ampGain}, {28'h0, v[15], v[12], v[9:8]});
      if (i == 0 || i == 4 || i > 11) begin
        chk("channel", {20'h0, channelConnect}, (ch < 12) ? 32'h1 << ch : 32'h0);
        chk("source", coreCtrl.source, (ch < 12) ? adrc_pkg::SRC_EXT : adrc_pkg::SRC_NONE);
      end else begin
        chk("channel", {20'h0, channelConnect}, 32'h0);
        chk("source", coreCtrl.source, (i < 4) ? adrc_pkg::SRC_AVDD + i - 1 : (i < 8) ? adrc_pkg::SRC_AMP + i - 5
          : adrc_pkg::SRC_GND);
      end
      rchk("input select", adrc_pkg::OFF_INPUT_CLOCK, {24'h0, i[3:0], v[3:0] & 4'h7});
      rchk("amp reference", adrc_pkg::OFF_AMP_REF, {24'h0, v[15:8] & adrc_pkg::MASK_AMP_REF});
    end
    for (int i = 0; i < 6; i++) begin
      v = rnd();
      al = i[0];
      sample <= v[11:0];
      latency <= 8'h30 + {3'h0, v[16:12]};
      divCode = i[2:0];
      wr(adrc_pkg::OFF_INPUT_CLOCK, {5'h00, i[2:0]});
      wr(adrc_pkg::OFF_IRQ_ENABLE, {7'h0, i[1]});
      wr(adrc_pkg::OFF_MAIN_CTRL, {3'h5, al, 4'h0});
      wr(adrc_pkg::OFF_MAIN_CTRL, {3'h1, al, 4'h0});
      expQ.push_back(int'(v[11:0]));
      rchk("busy", adrc_pkg::OFF_MAIN_CTRL, {24'h0, 3'h3, al, 4'h0});
      if (i == 2) begin
        wr(adrc_pkg::OFF_MAIN_CTRL, {3'h5, al, 4'h0});
        wr(adrc_pkg::OFF_MAIN_CTRL, {3'h1, al, 4'h0});
        rchk("start while busy", adrc_pkg::OFF_IRQ_STATUS, 32'h2);
      end
      rd = 32'h40;
      while (rd[6]) rd8(adrc_pkg::OFF_MAIN_CTRL);
      ex = expQ.pop_front();
      eh = al ? {28'h0, ex[11:8]} : {24'h0, ex[11:4]};
      el = al ? {24'h0, ex[7:0]} : {24'h0, ex[3:0], 4'h0};
      rchk("result high", adrc_pkg::OFF_RESULT_HIGH, eh);
      rchk("result low", adrc_pkg::OFF_RESULT_LOW, el);
      chk("irq", {31'h0, irq}, {31'h0, i[1]});
      rchk("status", adrc_pkg::OFF_IRQ_STATUS, (i == 2) ? 32'h3 : 32'h1);
      wr(adrc_pkg::OFF_IRQ_CLEAR, 8'h03);
      @(negedge clk);
      chk("irq cleared", {31'h0, irq}, 32'h0);
    end
    wr(adrc_pkg::OFF_MAIN_CTRL, 8'h90);
    wr(adrc_pkg::OFF_MAIN_CTRL, 8'h10);
    rchk("disabled busy", adrc_pkg::OFF_MAIN_CTRL, 32'h10);
    rchk("disabled start", adrc_pkg::OFF_IRQ_STATUS, 32'h2);
    rchk("kept high", adrc_pkg::OFF_RESULT_HIGH, {28'h0, v[11:8]});
    rchk("kept low", adrc_pkg::OFF_RESULT_LOW, {24'h0, v[7:0]});
    close_out();
  end
endmodule : adrc_register_control_tb

// ---- verilog/adrc_register_control.sv ----
// Register control and result logic of a 12-bit converter, AXI4-Lite slave.
// Assumes the analog core pulses done with valid data for one clock at end of conversion.
//
// Design decisions made here: the register offsets and the AXI4-Lite register port.
module adrc_register_control (
  input wire logic clk, // System clock
  input wire logic reset, // Async reset, active high
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  output adrc_pkg::adrc_core_ctrl_t coreCtrl, // Controls to analog core
  input wire adrc_pkg::adrc_core_stat_t coreStat, // Status from analog core
  output logic [11:0] channelConnect, // One-hot external channel switch
  input wire logic [11:0] pinAnalogSelect, // Pin-sharing analog selection
  output logic [11:0] pinDigitalEnable, // Digital function kept on pin
  input wire logic [11:0] pinPullRequest, // Pull-high requested by port logic
  output logic [11:0] pinPullEnable, // Pull-high actually applied
  output logic ampEnable, // Gain amplifier enable
  output logic ampInputSel, // Amplifier input select
  output logic [1:0] ampGain, // Amplifier gain select
  output logic bandgapEnable, // Bandgap reference enable
  output logic irq // Level interrupt
);

  typedef struct packed {
    logic awHeld;
    logic [7:0] awAddr;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
    logic [7:0] mainCtrl;
    logic [7:0] inputClock;
    logic [7:0] ampRef;
    logic [7:0] bandgap;
    logic [11:0] result;
    logic [1:0] irqStatus;
    logic [1:0] irqEnable;
    adrc_pkg::adrc_state_t state;
    logic startPulse;
    logic [6:0] divCnt;
    logic convClkEn;
  } adrc_regs_t;

  adrc_regs_t s_q;
  adrc_regs_t s_d;

  // Divider terminal count for the clock field
  function automatic logic [6:0] div_limit(input logic [2:0] code);
    div_limit = 7'((8'h01 << code) - 8'h01);
  endfunction : div_limit

  function automatic adrc_pkg::adrc_src_t decode_source(input logic [3:0] sel);
    case (sel)
      4'h1: decode_source = adrc_pkg::SRC_AVDD;
      4'h2: decode_source = adrc_pkg::SRC_AVDD_2;
      4'h3: decode_source = adrc_pkg::SRC_AVDD_4;
      4'h5: decode_source = adrc_pkg::SRC_AMP;
      4'h6: decode_source = adrc_pkg::SRC_AMP_2;
      4'h7: decode_source = adrc_pkg::SRC_AMP_4;
      4'h8, 4'h9, 4'hA, 4'hB: decode_source = adrc_pkg::SRC_GND;
      default: decode_source = adrc_pkg::SRC_EXT;
    endcase
  endfunction : decode_source

  function automatic logic [31:0] read_mux(input adrc_regs_t s, input logic [7:0] addr);
    logic [7:0] v;
    v = 8'h00;
    case (addr)
      adrc_pkg::OFF_RESULT_LOW: v = s.mainCtrl[adrc_pkg::MC_ALIGN] ? s.result[7:0]
                                     : {s.result[3:0], 4'h0};
      adrc_pkg::OFF_RESULT_HIGH: v = s.mainCtrl[adrc_pkg::MC_ALIGN] ? {4'h0, s.result[11:8]}
                                      : s.result[11:4];
      adrc_pkg::OFF_MAIN_CTRL: v = s.mainCtrl;
      adrc_pkg::OFF_INPUT_CLOCK: v = s.inputClock;
      adrc_pkg::OFF_AMP_REF: v = s.ampRef;
      adrc_pkg::OFF_BANDGAP: v = s.bandgap;
      adrc_pkg::OFF_IRQ_STATUS: v = {6'h00, s.irqStatus};
      adrc_pkg::OFF_IRQ_ENABLE: v = {6'h00, s.irqEnable};
      default: v = 8'h00;
    endcase
    read_mux = {24'h000000, v};
  endfunction : read_mux

  function automatic logic known_addr(input logic [7:0] addr);
    known_addr = (addr[1:0] == 2'h0) && (addr <= adrc_pkg::OFF_IRQ_CLEAR);
  endfunction : known_addr

  logic doWrite;
  logic [7:0] wByte;
  logic startSeq;
  logic [3:0] chanSel;
  adrc_pkg::adrc_src_t srcSel;

  assign doWrite = s_q.awHeld && s_q.wHeld && !s_q.bValid;
  assign wByte = s_q.wData[7:0];
  assign chanSel = s_q.mainCtrl[3:0];
  assign srcSel = decode_source(s_q.inputClock[7:4]);

  // Start bit written low while it was high: the high-then-low sequence
  assign startSeq = doWrite && s_q.wStrb[0] && (s_q.awAddr == adrc_pkg::OFF_MAIN_CTRL)
                    && s_q.mainCtrl[adrc_pkg::MC_START] && !wByte[adrc_pkg::MC_START];

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_d = s_q;
    s_d.startPulse = 1'b0;
    // Bus channels
    if (s_axi_awvalid && !s_q.awHeld) begin
      s_d.awHeld = 1'b1;
      s_d.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_q.wHeld) begin
      s_d.wHeld = 1'b1;
      s_d.wData = s_axi_wdata;
      s_d.wStrb = s_axi_wstrb;
    end
    if (s_q.bValid && s_axi_bready) begin
      s_d.bValid = 1'b0;
    end
    if (doWrite) begin
      s_d.awHeld = 1'b0;
      s_d.wHeld = 1'b0;
      s_d.bValid = 1'b1;
      s_d.bResp = known_addr(s_q.awAddr) ? adrc_pkg::RESP_OKAY : adrc_pkg::RESP_SLVERR;
      if (s_q.wStrb[0]) begin
        case (s_q.awAddr)
          adrc_pkg::OFF_MAIN_CTRL: s_d.mainCtrl = (wByte & adrc_pkg::MASK_MAIN)
                                   | (s_q.mainCtrl & ~adrc_pkg::MASK_MAIN);
          adrc_pkg::OFF_INPUT_CLOCK: s_d.inputClock = wByte & adrc_pkg::MASK_INPUT_CLOCK;
          adrc_pkg::OFF_AMP_REF: s_d.ampRef = wByte & adrc_pkg::MASK_AMP_REF;
          adrc_pkg::OFF_BANDGAP: s_d.bandgap = wByte & adrc_pkg::MASK_BANDGAP;
          adrc_pkg::OFF_IRQ_ENABLE: s_d.irqEnable = wByte[1:0];
          adrc_pkg::OFF_IRQ_CLEAR: s_d.irqStatus = s_q.irqStatus & ~wByte[1:0];
          default: s_d.rResp = s_q.rResp;
        endcase
      end
    end
    if (s_q.rValid && s_axi_rready) begin
      s_d.rValid = 1'b0;
    end
    if (s_axi_arvalid && !s_q.rValid) begin
      s_d.rValid = 1'b1;
      s_d.rData = read_mux(s_q, s_axi_araddr);
      s_d.rResp = known_addr(s_axi_araddr) ? adrc_pkg::RESP_OKAY : adrc_pkg::RESP_SLVERR;
    end

    // Conversion clock divider runs only while converting
    s_d.convClkEn = 1'b0;
    if (s_q.state == adrc_pkg::ST_CONVERT) begin
      if (s_q.divCnt >= div_limit(s_q.inputClock[2:0])) begin
        s_d.divCnt = 7'h00;
        s_d.convClkEn = 1'b1;
      end else begin
        s_d.divCnt = s_q.divCnt + 7'h01;
      end
    end else begin
      s_d.divCnt = 7'h00;
    end

    // Conversion sequencing
    case (s_q.state)
      adrc_pkg::ST_IDLE: begin
        if (startSeq) begin
          // A start write that also clears enable must not launch a conversion
          if (s_q.mainCtrl[adrc_pkg::MC_ENABLE] && wByte[adrc_pkg::MC_ENABLE]) begin
            s_d.state = adrc_pkg::ST_CONVERT;
            s_d.startPulse = 1'b1;
            s_d.mainCtrl[adrc_pkg::MC_BUSY] = 1'b1;
          end else begin
            s_d.irqStatus[adrc_pkg::IRQ_IGNORED] = 1'b1;
          end
        end
      end
      adrc_pkg::ST_CONVERT: begin
        if (startSeq) begin
          s_d.irqStatus[adrc_pkg::IRQ_IGNORED] = 1'b1;
        end
        if (!s_q.mainCtrl[adrc_pkg::MC_ENABLE]) begin
          // Disabled mid-conversion: abort, result kept
          s_d.state = adrc_pkg::ST_IDLE;
          s_d.mainCtrl[adrc_pkg::MC_BUSY] = 1'b0;
        end else if (coreStat.done) begin
          s_d.result = coreStat.data;
          s_d.mainCtrl[adrc_pkg::MC_BUSY] = 1'b0;
          s_d.state = adrc_pkg::ST_IDLE;
          s_d.irqStatus[adrc_pkg::IRQ_DONE] = 1'b1;
        end
      end
      default: s_d.state = adrc_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Analog routing
  genvar gi;
  generate
    for (gi = 0; gi < 12; gi++) begin : g_pin
      assign channelConnect[gi] = s_q.mainCtrl[adrc_pkg::MC_ENABLE] && (srcSel == adrc_pkg::SRC_EXT)
                                  && (chanSel == 4'(gi));
      assign pinDigitalEnable[gi] = !pinAnalogSelect[gi];
      assign pinPullEnable[gi] = pinPullRequest[gi] && !pinAnalogSelect[gi];
    end
  endgenerate

  always_comb begin
    coreCtrl.powerOn = s_q.mainCtrl[adrc_pkg::MC_ENABLE];
    coreCtrl.startPulse = s_q.startPulse;
    coreCtrl.convClkEn = s_q.convClkEn;
    if (!s_q.mainCtrl[adrc_pkg::MC_ENABLE]) begin
      coreCtrl.source = adrc_pkg::SRC_NONE;
    end else if (srcSel == adrc_pkg::SRC_EXT && chanSel >= adrc_pkg::NUM_CHANNELS) begin
      coreCtrl.source = adrc_pkg::SRC_NONE;
    end else begin
      coreCtrl.source = srcSel;
    end
    case (s_q.ampRef[3:2])
      2'h0: coreCtrl.reference = adrc_pkg::REF_AVDD;
      2'h1: coreCtrl.reference = adrc_pkg::REF_PIN;
      default: coreCtrl.reference = adrc_pkg::REF_AMP;
    endcase
  end

  assign ampEnable = s_q.ampRef[7];
  assign ampInputSel = s_q.ampRef[4];
  assign ampGain = s_q.ampRef[1:0];
  assign bandgapEnable = s_q.bandgap[0];
  assign irq = |(s_q.irqStatus & s_q.irqEnable);

  assign s_axi_awready = !s_q.awHeld;
  assign s_axi_wready = !s_q.wHeld;
  assign s_axi_bvalid = s_q.bValid;
  assign s_axi_bresp = s_q.bResp;
  assign s_axi_arready = !s_q.rValid;
  assign s_axi_rvalid = s_q.rValid;
  assign s_axi_rdata = s_q.rData;
  assign s_axi_rresp = s_q.rResp;

endmodule : adrc_register_control
